// File: inc/ppc_pkg.sv
// package of offsets, field positions and reset values for the phy control bank
`default_nettype none
package ppc_pkg;

    // ====================================================================
    // register offsets
    localparam logic [15:0] PPC_PHY_POWER_MANAGEMENT_OFFSET = 16'h0e14;
    localparam logic [15:0] PPC_PHY_CONFIGURATION_OFFSET    = 16'h0e38;
    localparam logic [15:0] PPC_IRQ_STATUS_OFFSET           = 16'h0e40;
    localparam logic [15:0] PPC_IRQ_MASK_OFFSET             = 16'h0e44;

    // ====================================================================
    // configuration register fields
    localparam int PPC_CFG_AUTO_XOVER_BIT  = 0;
    localparam int PPC_CFG_LOW_AMP_10_BIT  = 1;
    localparam int PPC_CFG_EEE_FAST_BIT    = 2;
    localparam int PPC_CFG_EEE_GIGA_BIT    = 3;
    localparam int PPC_CFG_WIDTH           = 4;
    localparam logic [3:0] PPC_CFG_RESET   = 4'hc;

    // ====================================================================
    // power management register fields
    localparam int PPC_PM_PWR_DOWN_BIT     = 0;
    localparam int PPC_PM_ACT_LOW_SPD_BIT  = 1;
    localparam int PPC_PM_SPD_REDUCE_BIT   = 2;
    localparam int PPC_PM_NO_GIGA_LP_BIT   = 3;
    localparam int PPC_PM_ENERGY_BIT       = 4;
    localparam int PPC_PM_DISCONNECT_BIT   = 5;
    localparam int PPC_PM_NO_GIGA_BIT      = 6;
    localparam int PPC_PM_B2B_BIT          = 7;
    localparam int PPC_PM_RST_DONE_BIT     = 8;
    localparam int PPC_PM_NO_FAST_LP_BIT   = 9;
    localparam int PPC_PM_WIDTH            = 10;
    localparam logic [9:0] PPC_PM_RESET    = 10'h08d;
    // writable bits only (status bits 4 and 8 are read-only)
    localparam logic [9:0] PPC_PM_WR_MASK  = 10'h2ef;

    // ====================================================================
    // interrupt status fields
    localparam int PPC_IRQ_ENERGY_BIT      = 0;
    localparam int PPC_IRQ_RST_DONE_BIT    = 1;
    localparam int PPC_IRQ_RENEG_BIT       = 2;
    localparam int PPC_IRQ_WIDTH           = 3;

endpackage : ppc_pkg
`default_nettype wire

// File: logic/ppc_sync.sv
// two flop synchroniser for pin level inputs
`timescale 1ns/1ps
`default_nettype none
module ppc_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_sys_clk,  // system clock
    input  wire logic             i_reset,    // async reset, high
    input  wire logic             i_ce,       // clock enable
    input  wire logic [WIDTH-1:0] i_async,    // level from outside
    output logic      [WIDTH-1:0] o_sync      // synchronised level
);
    logic [WIDTH-1:0] meta_reg;

    // ====================================================================
    // first flop feeds only the second
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            meta_reg <= '0;
            o_sync   <= '0;
        end else if (i_ce) begin
            meta_reg <= i_async;
            o_sync   <= meta_reg;
        end
    end
endmodule : ppc_sync
`default_nettype wire

// File: logic/ppc_bank.sv
// phy configuration and power management register bank
// Behaviour
// - auto crossover enable at config bit 0 loads from an nv strap and drives the phy.
// - config bit 1, reset 0, enables the low amplitude 10 mb/s mode.
// - config bit 2, reset 1, advertises fast eee and any change pulses a renegotiate.
// - config bit 3, reset 1, advertises gigabit eee and any change pulses a renegotiate.
// - reserved upper bits of both registers are held and read as zero.
// - power bit 0, reset from an nv strap, enables smart power down.
// - power bit 1, reset 0, asks for a low speed link in every power state.
// - power bit 2, strap loaded, allows speed reduction outside the active state.
// - power bit 3, strap loaded, forbids gigabit outside the active state.
// - power bit 4 is a read-only sticky flag set when link energy is seen.
// - while disconnect is set the energy flag reads as one.
// - power bit 5 forces the phy into link disconnect at once.
// - power bit 6, strap loaded, forbids gigabit in every power mode.
// - power bit 7, reset 1, enables back to back smart power down.
// - power bit 8 is a read-only sticky flag set when the phy reset is released.
// - power bit 9, strap loaded, forbids fast and gigabit outside the active state.
`timescale 1ns/1ps
`default_nettype none
module ppc_bank
    import ppc_pkg::*;
(
    input  wire logic        i_sys_clk,            // 50 mhz clock
    input  wire logic        i_reset,              // async reset, high
    input  wire logic        i_ce,                 // clock enable
    input  wire logic [15:0] i_addr,               // byte address
    input  wire logic [31:0] i_wdata,              // write data
    input  wire logic        i_wr,                 // write strobe
    input  wire logic        i_rd,                 // read strobe
    output logic      [31:0] o_rdata,              // read data, cycle after strobe
    input  wire logic        i_nv_auto_xover,      // strap: crossover default
    input  wire logic        i_nv_pwr_down,        // strap: smart power down
    input  wire logic        i_nv_spd_reduce,      // strap: speed reduce
    input  wire logic        i_nv_no_giga_lp,      // strap: no gigabit low power
    input  wire logic        i_nv_no_giga,         // strap: no gigabit
    input  wire logic        i_nv_no_fast_lp,      // strap: no fast low power
    input  wire logic        i_phy_energy,         // pin: energy on link
    input  wire logic        i_phy_rst_done,       // pin: phy reset released
    input  wire logic        i_in_d0a,             // function in active state
    output logic             o_auto_xover,         // auto crossover enable
    output logic             o_low_amp_10,         // low amplitude 10 mb/s
    output logic             o_advertise_eee_fast_speed, // fast eee advert
    output logic             o_advertise_eee_gigabit,    // gigabit eee advert
    output logic             o_renegotiate,        // one cycle link drop pulse
    output logic             o_smart_power_down_enable,  // smart power down
    output logic             o_active_state_low_speed_link, // low speed always
    output logic             o_low_power_speed_reduce_enable, // speed reduce
    output logic             o_power_down_back_to_back_enable, // b2b spd
    output logic             o_link_disconnect,    // force link disconnect
    output logic             o_giga_allowed,       // gigabit permitted now
    output logic             o_fast_allowed,       // 100 mb/s permitted now
    output logic             o_irq                 // level interrupt
);

    // ====================================================================
    // declarations
    logic [PPC_CFG_WIDTH-1:0] cfg_reg;
    logic [PPC_PM_WIDTH-1:0]  pm_reg;
    logic                     energy_reg;
    logic                     rst_done_reg;
    logic [PPC_IRQ_WIDTH-1:0] irq_stat_reg;
    logic [PPC_IRQ_WIDTH-1:0] irq_mask_reg;
    logic                     strap_done_reg;
    logic                     energy_s;
    logic                     rst_done_s;
    logic                     rst_done_d_reg;
    logic                     d0a_s;
    logic                     wr_cfg;
    logic                     wr_pm;
    logic                     rd_pm;
    logic                     rd_irq;
    logic                     eee_change;
    logic                     rst_done_rise;
    logic [PPC_PM_WIDTH-1:0]  pm_view;
    logic [PPC_CFG_WIDTH-1:0] cfg_next;

    // address match used by every decode
    function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
        hit = (a == off);
    endfunction : hit

    // ====================================================================
    // pin synchronisers
    ppc_sync #(.WIDTH(3)) u_sync (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_ce      (i_ce),
        .i_async   ({i_phy_energy, i_phy_rst_done, i_in_d0a}),
        .o_sync    ({energy_s, rst_done_s, d0a_s})
    );

    // ====================================================================
    // decode
    assign wr_cfg   = i_wr && hit(i_addr, PPC_PHY_CONFIGURATION_OFFSET);
    assign wr_pm    = i_wr && hit(i_addr, PPC_PHY_POWER_MANAGEMENT_OFFSET);
    assign rd_pm    = i_rd && hit(i_addr, PPC_PHY_POWER_MANAGEMENT_OFFSET);
    assign rd_irq   = i_rd && hit(i_addr, PPC_IRQ_STATUS_OFFSET);
    assign cfg_next = i_wdata[PPC_CFG_WIDTH-1:0];
    assign eee_change = wr_cfg && i_ce && strap_done_reg &&
        (cfg_next[PPC_CFG_EEE_GIGA_BIT:PPC_CFG_EEE_FAST_BIT] !=
         cfg_reg[PPC_CFG_EEE_GIGA_BIT:PPC_CFG_EEE_FAST_BIT]);
    assign rst_done_rise = rst_done_s && !rst_done_d_reg;

    always_comb begin
        pm_view = pm_reg & PPC_PM_WR_MASK;
        pm_view[PPC_PM_ENERGY_BIT]   = energy_reg | pm_reg[PPC_PM_DISCONNECT_BIT];
        pm_view[PPC_PM_RST_DONE_BIT] = rst_done_reg;
    end

    // ====================================================================
    // configuration register; straps caught once after reset release
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            cfg_reg        <= PPC_CFG_RESET;
            strap_done_reg <= 1'b0;
        end else if (i_ce) begin
            if (!strap_done_reg) begin
                cfg_reg[PPC_CFG_AUTO_XOVER_BIT] <= i_nv_auto_xover;
                strap_done_reg <= 1'b1;
            end else if (wr_cfg) begin
                cfg_reg <= cfg_next;
            end
        end
    end

    // ====================================================================
    // power management register, status bits masked off on write
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            pm_reg <= PPC_PM_RESET;
        end else if (i_ce) begin
            if (!strap_done_reg) begin
                pm_reg[PPC_PM_PWR_DOWN_BIT]   <= i_nv_pwr_down;
                pm_reg[PPC_PM_SPD_REDUCE_BIT] <= i_nv_spd_reduce;
                pm_reg[PPC_PM_NO_GIGA_LP_BIT] <= i_nv_no_giga_lp;
                pm_reg[PPC_PM_NO_GIGA_BIT]    <= i_nv_no_giga;
                pm_reg[PPC_PM_NO_FAST_LP_BIT] <= i_nv_no_fast_lp;
            end else if (wr_pm) begin
                // reserved and status bits never stored
                pm_reg <= i_wdata[PPC_PM_WIDTH-1:0] & PPC_PM_WR_MASK;
            end
        end
    end

    // ====================================================================
    // sticky status flags; a live event beats the clearing read
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            energy_reg     <= 1'b0;
            rst_done_reg   <= 1'b0;
            rst_done_d_reg <= 1'b0;
        end else if (i_ce) begin
            rst_done_d_reg <= rst_done_s;
            if (energy_s) begin
                energy_reg <= 1'b1;
            end else if (rd_pm) begin
                energy_reg <= 1'b0;
            end
            if (rst_done_rise) begin
                rst_done_reg <= 1'b1;
            end else if (rd_pm) begin
                rst_done_reg <= 1'b0;
            end
        end
    end

    // ====================================================================
    // interrupt status, mask and output
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            irq_stat_reg <= '0;
            irq_mask_reg <= '0;
            o_irq        <= 1'b0;
        end else if (i_ce) begin
            irq_stat_reg <= (rd_irq ? '0 : irq_stat_reg) |
                            {eee_change, rst_done_rise, energy_s};
            if (i_wr && hit(i_addr, PPC_IRQ_MASK_OFFSET)) begin
                irq_mask_reg <= i_wdata[PPC_IRQ_WIDTH-1:0];
            end
            o_irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    // ====================================================================
    // read data, one cycle after strobe; unmapped reads zero
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= '0;
            if (i_rd) begin
                if (hit(i_addr, PPC_PHY_CONFIGURATION_OFFSET)) begin
                    o_rdata <= {28'h0, cfg_reg};
                end else if (rd_pm) begin
                    o_rdata <= {22'h0, pm_view};
                end else if (rd_irq) begin
                    o_rdata <= {29'h0, irq_stat_reg};
                end else if (hit(i_addr, PPC_IRQ_MASK_OFFSET)) begin
                    o_rdata <= {29'h0, irq_mask_reg};
                end
            end
        end
    end

    // ====================================================================
    // phy controls, all registered
    always_ff @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            o_auto_xover                     <= 1'b0;
            o_low_amp_10                     <= 1'b0;
            o_advertise_eee_fast_speed       <= 1'b0;
            o_advertise_eee_gigabit          <= 1'b0;
            o_renegotiate                    <= 1'b0;
            o_smart_power_down_enable        <= 1'b0;
            o_active_state_low_speed_link    <= 1'b0;
            o_low_power_speed_reduce_enable  <= 1'b0;
            o_power_down_back_to_back_enable <= 1'b0;
            o_link_disconnect                <= 1'b0;
            o_giga_allowed                   <= 1'b0;
            o_fast_allowed                   <= 1'b0;
        end else if (i_ce) begin
            o_auto_xover <= cfg_reg[PPC_CFG_AUTO_XOVER_BIT];
            o_low_amp_10 <= cfg_reg[PPC_CFG_LOW_AMP_10_BIT];
            o_advertise_eee_fast_speed <= cfg_reg[PPC_CFG_EEE_FAST_BIT];
            o_advertise_eee_gigabit <= cfg_reg[PPC_CFG_EEE_GIGA_BIT];
            o_renegotiate <= eee_change;
            o_smart_power_down_enable <= pm_reg[PPC_PM_PWR_DOWN_BIT];
            o_active_state_low_speed_link <= pm_reg[PPC_PM_ACT_LOW_SPD_BIT];
            o_low_power_speed_reduce_enable <= pm_reg[PPC_PM_SPD_REDUCE_BIT];
            o_power_down_back_to_back_enable <= pm_reg[PPC_PM_B2B_BIT];
            o_link_disconnect <= wr_pm && strap_done_reg ?
                i_wdata[PPC_PM_DISCONNECT_BIT] : pm_reg[PPC_PM_DISCONNECT_BIT];
            o_giga_allowed <= !pm_reg[PPC_PM_NO_GIGA_BIT] &&
                (d0a_s || (!pm_reg[PPC_PM_NO_GIGA_LP_BIT] &&
                           !pm_reg[PPC_PM_NO_FAST_LP_BIT]));
            o_fast_allowed <= d0a_s || !pm_reg[PPC_PM_NO_FAST_LP_BIT];
        end
    end

    // ====================================================================
    // checks
    // change pulses once
    reneg_pulse_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && eee_change |=> o_renegotiate)
        else $error("renegotiate pulse missing");
    reneg_cause_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        $rose(o_renegotiate) |-> $past(eee_change))
        else $error("renegotiate without cause");
    reserved_zero_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        o_rdata[31:10] == 22'h0)
        else $error("reserved bits nonzero");
    energy_forced_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && rd_pm && pm_reg[PPC_PM_DISCONNECT_BIT] |=> o_rdata[PPC_PM_ENERGY_BIT])
        else $error("energy flag not forced");
    energy_latch_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && energy_s |=> energy_reg)
        else $error("energy not latched");
    flag_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        energy_reg && !rd_pm |=> energy_reg)
        else $error("energy flag dropped without read");
    rstdone_latch_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && rst_done_rise |=> rst_done_reg)
        else $error("reset complete not latched");
    disconnect_now_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && wr_pm && strap_done_reg && i_wdata[PPC_PM_DISCONNECT_BIT]
        |=> o_link_disconnect)
        else $error("disconnect delayed");
    giga_block_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && pm_reg[PPC_PM_NO_GIGA_BIT] |=> !o_giga_allowed)
        else $error("gigabit allowed while disabled");
    xover_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && strap_done_reg |=> o_auto_xover == $past(cfg_reg[PPC_CFG_AUTO_XOVER_BIT]))
        else $error("crossover output stale");
    low_amp_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && strap_done_reg |=> o_low_amp_10 == $past(cfg_reg[PPC_CFG_LOW_AMP_10_BIT]))
        else $error("low amplitude output stale");
    spd_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && strap_done_reg |=>
        o_smart_power_down_enable == $past(pm_reg[PPC_PM_PWR_DOWN_BIT]))
        else $error("smart power down output stale");
    low_speed_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && strap_done_reg |=>
        o_active_state_low_speed_link == $past(pm_reg[PPC_PM_ACT_LOW_SPD_BIT]))
        else $error("low speed output stale");
    reduce_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && strap_done_reg |=>
        o_low_power_speed_reduce_enable == $past(pm_reg[PPC_PM_SPD_REDUCE_BIT]))
        else $error("speed reduce output stale");
    // back to back output follows register
    b2b_drive_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && strap_done_reg |=>
        o_power_down_back_to_back_enable == $past(pm_reg[PPC_PM_B2B_BIT]))
        else $error("back to back output stale");
    giga_lp_block_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && pm_reg[PPC_PM_NO_GIGA_LP_BIT] && !d0a_s |=> !o_giga_allowed)
        else $error("gigabit allowed outside active state");
    fast_block_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && pm_reg[PPC_PM_NO_FAST_LP_BIT] && !d0a_s |=> !o_fast_allowed)
        else $error("fast speed allowed outside active state");
    rstdone_hold_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        rst_done_reg && !rd_pm |=> rst_done_reg)
        else $error("reset flag dropped without read");
    status_ro_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
        i_ce && wr_pm && strap_done_reg |=>
        !pm_reg[PPC_PM_ENERGY_BIT] && !pm_reg[PPC_PM_RST_DONE_BIT])
        else $error("status bit stored by write");

endmodule : ppc_bank
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for the phy control register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import ppc_pkg::*;
;
    // ====================================================================
    // stimulus and observation signals
    logic        i_sys_clk, i_reset, i_ce, i_wr, i_rd;
    logic [15:0] i_addr;
    logic [31:0] i_wdata, o_rdata;
    logic        nv_x, nv_s, nv_r, nv_g3, nv_g6, nv_f9, en_pin, rd_pin, d0a;
    logic        o_xo, o_la, o_ef, o_eg, o_rn, o_sp, o_ls, o_lr, o_bb, o_dc, o_ga, o_fa, o_irq;
    int          err_total, n_tests, cyc;

    ppc_bank dut_u (.i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_ce(i_ce), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
        .i_nv_auto_xover(nv_x), .i_nv_pwr_down(nv_s), .i_nv_spd_reduce(nv_r),
        .i_nv_no_giga_lp(nv_g3), .i_nv_no_giga(nv_g6), .i_nv_no_fast_lp(nv_f9),
        .i_phy_energy(en_pin), .i_phy_rst_done(rd_pin), .i_in_d0a(d0a),
        .o_auto_xover(o_xo), .o_low_amp_10(o_la), .o_advertise_eee_fast_speed(o_ef),
        .o_advertise_eee_gigabit(o_eg), .o_renegotiate(o_rn),
        .o_smart_power_down_enable(o_sp), .o_active_state_low_speed_link(o_ls),
        .o_low_power_speed_reduce_enable(o_lr), .o_power_down_back_to_back_enable(o_bb),
        .o_link_disconnect(o_dc), .o_giga_allowed(o_ga), .o_fast_allowed(o_fa),
        .o_irq(o_irq));

    // ====================================================================
    // clock, and a cycle ceiling so a hang still reaches the verdict
    initial begin
        i_sys_clk = 1'b0;
        forever #10 i_sys_clk = ~i_sys_clk;
    end
    always @(posedge i_sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            err_total = err_total + 1;
            conclude();
        end
    end

    // ====================================================================
    // shared helpers: compare, bus cycles, cycle wait, verdict
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            err_total = err_total + 1;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge i_sys_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        #1 d = o_rdata;
    endtask : rd
    task automatic rdchk(input string nm, input logic [15:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(nm, d, exp);
    endtask : rdchk
    // pins are synchronised, so give each pulse and its settling a few cycles
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_sys_clk);
        #1;
    endtask : wait_n
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : conclude

    // ====================================================================
    // scenario: values after reset with strap levels applied
    task automatic t_reset();
        chk("xover", o_xo, 1);
        chk("low amp", o_la, 0);
        chk("eee fast", o_ef, 1);
        chk("eee giga", o_eg, 1);
        chk("spd", o_sp, 1);
        chk("low speed", o_ls, 0);
        chk("reduce", o_lr, 1);
        chk("b2b", o_bb, 1);
        chk("disc", o_dc, 0);
        rdchk("cfg rst", PPC_PHY_CONFIGURATION_OFFSET, 32'h0000_000d);
        rdchk("pm rst", PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_008d);
        rdchk("mask rst", PPC_IRQ_MASK_OFFSET, 32'h0000_0000);
        rdchk("unmapped", 16'h0e00, 32'h0000_0000);
    endtask : t_reset

    // ====================================================================
    // scenario: eee advert change pulses renegotiate, same value does not
    task automatic t_cfg();
        wr(PPC_PHY_CONFIGURATION_OFFSET, 32'h0000_0004);
        chk("reneg on", o_rn, 1);
        wait_n(1);
        chk("reneg off", o_rn, 0);
        chk("giga adv", o_eg, 0);
        chk("xover off", o_xo, 0);
        wr(PPC_PHY_CONFIGURATION_OFFSET, 32'h0000_0004);
        chk("reneg same", o_rn, 0);
        wr(PPC_PHY_CONFIGURATION_OFFSET, 32'hffff_fff3);
        chk("reneg fast", o_rn, 1);
        wait_n(1);
        chk("fast adv", o_ef, 0);
        chk("low amp on", o_la, 1);
        rdchk("cfg resv", PPC_PHY_CONFIGURATION_OFFSET, 32'h0000_0003);
        rdchk("irq reneg", PPC_IRQ_STATUS_OFFSET, 32'h0000_0004);
        chk("irq masked", o_irq, 0);
    endtask : t_cfg

    // ====================================================================
    // scenario: power bits, disconnect forcing energy, speed permissions
    task automatic t_pm();
        wr(PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'hffff_ffff);
        wait_n(1);
        chk("disc on", o_dc, 1);
        chk("giga off", o_ga, 0);
        chk("fast d0a", o_fa, 1);
        rdchk("pm all", PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_02ff);
        d0a <= 1'b0;
        wait_n(5);
        chk("fast nd0a", o_fa, 0);
        wr(PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_0008);
        wait_n(1);
        chk("giga nd0a", o_ga, 0);
        chk("fast ok", o_fa, 1);
        chk("spd off", o_sp, 0);
        chk("reduce off", o_lr, 0);
        chk("b2b off", o_bb, 0);
        d0a <= 1'b1;
        wait_n(5);
        chk("giga d0a", o_ga, 1);
        wr(PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_0002);
        wait_n(1);
        chk("low speed on", o_ls, 1);
        // a write with the clock enable low must leave the register alone
        i_ce <= 1'b0;
        wr(PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_03ff);
        i_ce <= 1'b1;
        rdchk("pm ce", PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_0002);
    endtask : t_pm

    // ====================================================================
    // scenario: sticky flags hold past the event and clear on read
    task automatic t_sticky();
        en_pin <= 1'b1;
        wait_n(4);
        rdchk("energy live", PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_0012);
        en_pin <= 1'b0;
        wait_n(6);
        rdchk("energy set", PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_0012);
        rdchk("energy clr", PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_0002);
        rdchk("irq energy", PPC_IRQ_STATUS_OFFSET, 32'h0000_0001);
        wr(PPC_IRQ_MASK_OFFSET, 32'h0000_0002);
        rd_pin <= 1'b1;
        wait_n(4);
        rd_pin <= 1'b0;
        wait_n(6);
        chk("irq up", o_irq, 1);
        rdchk("irq rstd", PPC_IRQ_STATUS_OFFSET, 32'h0000_0002);
        wait_n(2);
        chk("irq down", o_irq, 0);
        rdchk("rstd set", PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_0102);
        rdchk("rstd clr", PPC_PHY_POWER_MANAGEMENT_OFFSET, 32'h0000_0002);
    endtask : t_sticky

    // ====================================================================
    // main sequence: reset, straps settle, scenarios, verdict
    initial begin
        {i_reset, i_ce, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 1'b1, 2'b00, 16'h0, 32'h0};
        {nv_x, nv_s, nv_r, nv_g3, nv_g6, nv_f9} = 6'b111100;
        {en_pin, rd_pin, d0a} = 3'b001;
        err_total = 0;
        n_tests = 0;
        cyc = 0;
        repeat (20) @(posedge i_sys_clk);
        i_reset <= 1'b0;
        wait_n(6);
        t_reset();
        t_cfg();
        t_pm();
        t_sticky();
        conclude();
    end
endmodule : tb_top
`default_nettype wire
